// ==== rtl/rclk_consts.svh ====
`ifndef RCLK_CONSTS_SVH
`define RCLK_CONSTS_SVH

// Register map
`define RCLK_CTRL_OFFSET       12'h000
`define RCLK_CTRL_RESET        32'h0000_0000
`define RCLK_CTRL_WR_MASK      32'h7FFF_BA0F
`define RCLK_CTRL_RSVD_MASK    32'h8000_44F0

// Field positions
`define RCLK_DIV_MSB           30
`define RCLK_DIV_LSB           16
`define RCLK_ON_BIT            15
`define RCLK_STOP_IN_IDLE_BIT          13
`define RCLK_OE_BIT            12
`define RCLK_RUN_DURING_SLEEP_BIT          11
`define RCLK_SWITCH_BIT        9
`define RCLK_ACTIVE_BIT        8
`define RCLK_SEL_MSB           3
`define RCLK_SEL_LSB           0

// Sources whose sleep behaviour ignores the run-in-sleep bit
`define RCLK_SEL_NO_RUN_DURING_SLEEP_MAX   4'h1

// Widths and counts
`define RCLK_DIV_W             15
`define RCLK_SEL_W             4
`define RCLK_NUM_SRC           16

`endif

// ==== rtl/rclk_pkg.sv ====
package rclk_pkg;

    // Control register image, bit 31 down to bit 0
    typedef struct packed {
        logic        rsvd31;
        logic [14:0] clock_divide_value;
        logic        module_on;
        logic        rsvd14;
        logic        stop_in_idle;
        logic        output_enable;
        logic        run_during_sleep;
        logic        rsvd10;
        logic        divider_switch_pending;
        logic        request_active;
        logic [3:0]  rsvd7_4;
        logic [3:0]  source_select;
    } rclk_ctrl_t;

    // Settings that the generator actually uses
    typedef struct packed {
        logic [14:0] div;
        logic [3:0]  sel;
    } rclk_setting_t;

    // Divider switch sequencer, one-hot
    typedef enum logic [2:0] {
        RCLK_SW_IDLE = 3'b001,
        RCLK_SW_WAIT = 3'b010,
        RCLK_SW_DONE = 3'b100
    } rclk_sw_state_t;

endpackage

// ==== rtl/rclk_divider.sv ====
`timescale 1ns/1ps
module rclk_divider #(
    parameter int DIV_W = 15
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             pclken,
    input  wire logic             run,
    input  wire logic             tick,
    input  wire logic [DIV_W-1:0] div,
    output logic                  clk_out
);

    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic             next_clk_out;

    // Toggle every div source ticks; zero passes ticks straight through
    always_comb
    begin
        next_count   = count;
        next_clk_out = clk_out;
        if (!run)
        begin
            next_count   = '0;
            next_clk_out = 1'b0;
        end
        else if (div == '0)
        begin
            next_count   = '0;
            next_clk_out = tick;
        end
        else if (tick)
        begin
            if (count >= div - 1'b1)
            begin
                next_count   = '0;
                next_clk_out = ~clk_out;
            end
            else
            begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count   <= '0;
            clk_out <= 1'b0;
        end
        else if (pclken)
        begin
            count   <= next_count;
            clk_out <= next_clk_out;
        end
    end

endmodule // rclk_divider

// ==== rtl/rclk_ctrl.sv ====
// Behaviour
// (R1) Bits 30..16 hold the 15-bit divide value for the selected source.
// (R2) Module on bit 15 starts the generator; clearing it stops it.
// (R3) Stop-in-idle bit 13 halts the generator while the device idles.
// (R4) Output enable bit 12 drives the reference clock onto its pin.
// (R5) Run-in-sleep bit 11 keeps the output toggling in sleep; else off.
// (R6) Run-in-sleep is ignored when source select is 0000 or 0001.
// (R7) Switch bit 9 reads 1 during a divider change; hardware clears it.
// (R8) While on, new divide and source apply only after switch is set.
// (R9) Bit 8 is read-only and reads 1 while a clock request is active.
// (R10) Software avoids changing divide or source while bit 8 reads 1.
// (R11) Bits 31, 14, 10 and 7..4 always read as zero.
// (R12) A disabled or halted generator holds its output low, glitch free.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "rclk_consts.svh"
module rclk_ctrl #(
    parameter int ADDR_W  = 12,
    parameter int DIV_W   = `RCLK_DIV_W,
    parameter int SEL_W   = `RCLK_SEL_W,
    parameter int NUM_SRC = `RCLK_NUM_SRC
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               pclken,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               idle_mode,
    input  wire logic               sleep_mode,
    input  wire logic [NUM_SRC-1:0] source_tick,
    output logic                    reference_clock_pin,
    output logic                    reference_clock_pin_oe
);

    rclk_pkg::rclk_ctrl_t     ctrl;
    rclk_pkg::rclk_ctrl_t     sw_regs;
    rclk_pkg::rclk_ctrl_t     wr_image;
    rclk_pkg::rclk_setting_t  act;
    rclk_pkg::rclk_sw_state_t sw_state;
    rclk_pkg::rclk_sw_state_t next_sw_state;

    logic        addr_hit;
    logic        setup_rd;
    logic        wr_en;
    logic [31:0] wmask;
    logic [31:0] ctrl_word;
    logic        sw_set;
    logic        sw_clear;
    logic        run_during_sleep_eff;
    logic        halted;
    logic        sel_tick;
    logic        gen_clk;
    logic        sw_load;
    logic        switch_flag;
    logic        req_active;

    // Bus decode
    assign addr_hit = (paddr == ADDR_W'(`RCLK_CTRL_OFFSET));
    assign setup_rd = psel && !penable && !pwrite;
    assign pready   = pclken;
    assign pslverr  = psel && penable && !addr_hit;
    assign wr_en    = psel && penable && pwrite && addr_hit && pclken;

    // Byte lanes limited to writable fields
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}}
                   & `RCLK_CTRL_WR_MASK;

    assign ctrl_word = ctrl;
    assign wr_image  = (ctrl_word & ~wmask) | (pwdata & wmask);

    // Switch bit: software only sets, hardware clears, set wins
    assign sw_set   = wr_en && pstrb[1] && pwdata[`RCLK_SWITCH_BIT];
    assign sw_clear = (sw_state == rclk_pkg::RCLK_SW_DONE);

    // Read data registered in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (pclken && setup_rd)
        begin
            if (addr_hit)
            begin
                prdata <= ctrl_word & ~`RCLK_CTRL_RSVD_MASK; // R11
            end
            else
            begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Register image assembled from its owners
    always_comb
    begin
        ctrl                        = sw_regs;
        ctrl.divider_switch_pending = switch_flag;
        ctrl.request_active         = req_active;
    end

    // Software-written fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sw_regs <= `RCLK_CTRL_RESET;
        end
        else if (wr_en)
        begin
            sw_regs.clock_divide_value <= wr_image.clock_divide_value; // R1
            sw_regs.module_on          <= wr_image.module_on;
            sw_regs.stop_in_idle       <= wr_image.stop_in_idle;
            sw_regs.output_enable      <= wr_image.output_enable;
            sw_regs.run_during_sleep   <= wr_image.run_during_sleep;
            sw_regs.source_select      <= wr_image.source_select;
        end
    end

    // Divider switch flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            switch_flag <= 1'b0;
        end
        else if (pclken)
        begin
            if (sw_set)
            begin
                switch_flag <= 1'b1; // R7
            end
            else if (sw_clear)
            begin
                switch_flag <= 1'b0; // R7
            end
        end
    end

    // Halt conditions
    assign run_during_sleep_eff = ctrl.run_during_sleep
                      && (ctrl.source_select > `RCLK_SEL_NO_RUN_DURING_SLEEP_MAX); // R6
    assign halted   = !ctrl.module_on                           // R2
                      || (ctrl.stop_in_idle && idle_mode)       // R3
                      || (sleep_mode && !run_during_sleep_eff);             // R5

    // Request status, set and cleared by hardware only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_active <= 1'b0;
        end
        else if (pclken)
        begin
            req_active <= !halted; // R9
        end
    end

    // Switch sequencer: wait for a low output phase before loading
    always_comb
    begin
        next_sw_state = sw_state;
        case (sw_state)
            rclk_pkg::RCLK_SW_IDLE:
            begin
                if (ctrl.divider_switch_pending)
                begin
                    next_sw_state = rclk_pkg::RCLK_SW_WAIT;
                end
            end
            rclk_pkg::RCLK_SW_WAIT:
            begin
                if (!gen_clk || halted)
                begin
                    next_sw_state = rclk_pkg::RCLK_SW_DONE;
                end
            end
            rclk_pkg::RCLK_SW_DONE:
            begin
                next_sw_state = rclk_pkg::RCLK_SW_IDLE;
            end
            default:
            begin
                next_sw_state = rclk_pkg::RCLK_SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sw_state <= rclk_pkg::RCLK_SW_IDLE;
        end
        else if (pclken)
        begin
            sw_state <= next_sw_state;
        end
    end

    assign sw_load = (sw_state == rclk_pkg::RCLK_SW_WAIT) && (!gen_clk || halted);

    // Settings in use: follow freely while off, else only on a switch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            act.div <= 15'h0000;
            act.sel <= 4'h0;
        end
        else if (pclken)
        begin
            if (!ctrl.module_on && wr_en) // R8
            begin
                act.div <= wr_image.clock_divide_value;
                act.sel <= wr_image.source_select;
            end
            else if (!ctrl.module_on || sw_load) // R8
            begin
                act.div <= ctrl.clock_divide_value;
                act.sel <= ctrl.source_select;
            end
        end
    end

    assign sel_tick = source_tick[act.sel];

    rclk_divider #(
        .DIV_W   (DIV_W)
    ) u_divider (
        .pclk    (pclk),
        .presetn (presetn),
        .pclken  (pclken),
        .run     (!halted), // R12
        .tick    (sel_tick),
        .div     (act.div),
        .clk_out (gen_clk)
    );

    // Pin drive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            reference_clock_pin    <= 1'b0;
            reference_clock_pin_oe <= 1'b0;
        end
        else if (pclken)
        begin
            reference_clock_pin    <= gen_clk && ctrl.output_enable; // R4
            reference_clock_pin_oe <= ctrl.output_enable;           // R4
        end
    end

    // Checks
    property p_div_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[3] && pstrb[2])
        |=> (ctrl.clock_divide_value == $past(pwdata[`RCLK_DIV_MSB:`RCLK_DIV_LSB]));
    endproperty
    a_div_write: assert property (p_div_write) // R1
        else $error("divide value not stored on write");

    property p_off_low;
        @(posedge pclk) disable iff (!presetn)
        (!ctrl.module_on && pclken) ##1 (!ctrl.module_on && pclken) |=> !gen_clk;
    endproperty
    a_off_low: assert property (p_off_low) // R2
        else $error("generator output not low while off");

    property p_idle_stop;
        @(posedge pclk) disable iff (!presetn)
        (ctrl.stop_in_idle && idle_mode && pclken) |=> !gen_clk;
    endproperty
    a_idle_stop: assert property (p_idle_stop) // R3
        else $error("generator kept running in idle");

    property p_pin_oe;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && pstrb[1]) ##1 pclken |=> (reference_clock_pin_oe == $past(pwdata[`RCLK_OE_BIT], 2));
    endproperty
    a_pin_oe: assert property (p_pin_oe) // R4
        else $error("pin enable does not follow output enable bit");

    property p_sleep_stop;
        @(posedge pclk) disable iff (!presetn)
        (sleep_mode && !ctrl.run_during_sleep && pclken) |=> !gen_clk;
    endproperty
    a_sleep_stop: assert property (p_sleep_stop) // R5
        else $error("output running in sleep without run-in-sleep");

    property p_sleep_ignore;
        @(posedge pclk) disable iff (!presetn)
        (sleep_mode && pclken && (ctrl.source_select <= `RCLK_SEL_NO_RUN_DURING_SLEEP_MAX)) |=> !gen_clk;
    endproperty
    a_sleep_ignore: assert property (p_sleep_ignore) // R6
        else $error("run-in-sleep honoured for a sleep-stopped source");

    property p_switch_clear;
        @(posedge pclk) disable iff (!presetn)
        (sw_state == rclk_pkg::RCLK_SW_DONE && pclken && !sw_set) |=> !ctrl.divider_switch_pending;
    endproperty
    a_switch_clear: assert property (p_switch_clear) // R7
        else $error("switch bit not cleared after load");

    property p_hold_off;
        @(posedge pclk) disable iff (!presetn)
        (ctrl.module_on && sw_state != rclk_pkg::RCLK_SW_WAIT) |=> $stable(act);
    endproperty
    a_hold_off: assert property (p_hold_off) // R8
        else $error("settings applied without a switch");

    property p_active;
        @(posedge pclk) disable iff (!presetn)
        pclken |=> (ctrl.request_active == !$past(halted));
    endproperty
    a_active: assert property (p_active) // R9
        else $error("request status does not track generator");

    property p_rsvd_zero;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite) |-> ((prdata & `RCLK_CTRL_RSVD_MASK) == 32'h0000_0000);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) // R11
        else $error("reserved bits read nonzero");

    property p_halt_low;
        @(posedge pclk) disable iff (!presetn)
        (halted && pclken) |=> !gen_clk;
    endproperty
    a_halt_low: assert property (p_halt_low) // R12
        else $error("halted generator output not low");

    property p_halt_pin;
        @(posedge pclk) disable iff (!presetn)
        (halted && pclken) ##1 pclken |=> !reference_clock_pin;
    endproperty
    a_halt_pin: assert property (p_halt_pin) // R12
        else $error("halted generator still drives the pin high");

endmodule // rclk_ctrl

// ==== verification/rclk_pin_model.sv ====
`timescale 1ns/1ps
module rclk_pin_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pin,
    input  wire logic        pin_oe,
    output logic             pin_level,
    output logic [31:0]      edge_count,
    output logic [31:0]      period
);
    logic        float_bit;
    logic        last_level;
    logic [31:0] since_rise;

    // Undriven pin wanders instead of keeping the last value
    assign pin_level = pin_oe ? pin : float_bit;

    // Rising edges and period of the driven clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            float_bit  <= 1'h0;
            last_level <= 1'h0;
            since_rise <= 32'h0;
            edge_count <= 32'h0;
            period     <= 32'h0;
        end
        else
        begin
            float_bit  <= ~float_bit;
            last_level <= pin_level;
            since_rise <= since_rise + 32'h1;
            if (pin_oe && pin_level && !last_level)
            begin
                edge_count <= edge_count + 32'h1;
                period     <= since_rise + 32'h1;
                since_rise <= 32'h0;
            end
        end
    end
endmodule // rclk_pin_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic        pclk;
    logic        presetn;
    logic        pclken;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        idle_mode;
    logic        sleep_mode;
    logic [15:0] source_tick;
    logic        pin;
    logic        pin_oe;
    logic        pin_level;
    logic [31:0] edge_count;
    logic [31:0] period;
    int          tick_cnt;
    int          err_count;
    int          n_tests;

    rclk_ctrl u_dut (
        .pclk                   (pclk),
        .presetn                (presetn),
        .pclken                 (pclken),
        .psel                   (psel),
        .penable                (penable),
        .pwrite                 (pwrite),
        .paddr                  (paddr),
        .pwdata                 (pwdata),
        .pstrb                  (pstrb),
        .prdata                 (prdata),
        .pready                 (pready),
        .pslverr                (pslverr),
        .idle_mode              (idle_mode),
        .sleep_mode             (sleep_mode),
        .source_tick            (source_tick),
        .reference_clock_pin    (pin),
        .reference_clock_pin_oe (pin_oe)
    );

    rclk_pin_model u_pin (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (pin),
        .pin_oe     (pin_oe),
        .pin_level  (pin_level),
        .edge_count (edge_count),
        .period     (period)
    );

    initial
    begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    // Source s ticks once every s+1 cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt    <= 0;
            source_tick <= 16'h0000;
        end
        else
        begin
            tick_cnt <= tick_cnt + 1;
            for (int s = 0; s < 16; s++)
            begin
                source_tick[s] <= ((tick_cnt % (s + 1)) == 0);
            end
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       input logic [3:0] st, output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'h1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic reg_write(input logic [31:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'h1, 12'h000, d, 4'hF, rd, er);
    endtask

    task automatic reg_expect(input string name, input logic [31:0] exp);
        logic [31:0] rd;
        logic        er;
        apb(1'h0, 12'h000, 32'h0, 4'h0, rd, er);
        check(name, rd, exp);
    endtask

    task automatic expect_run(input string name, input logic run);
        logic [31:0] c0;
        repeat (40) @(posedge pclk);
        c0 = edge_count;
        repeat (60) @(posedge pclk);
        check(name, {31'h0, edge_count != c0}, {31'h0, run});
        if (!run)
            check({name, " level"}, {31'h0, pin}, 32'h0);
    endtask

    task automatic test_regs;
        logic [31:0] rd;
        logic        er;
        reg_expect("reset image", 32'h0000_0000);
        reg_write(32'hFFFF_7CFF);
        repeat (2) @(posedge pclk);
        reg_expect("all ones image", 32'h7FFF_380F);
        apb(1'h1, 12'h000, 32'h0000_0000, 4'h1, rd, er);
        reg_expect("lane write", 32'h7FFF_3800);
        apb(1'h0, 12'h004, 32'h0, 4'h0, rd, er);
        check("unmapped error", {31'h0, er}, 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'h1, 12'h004, 32'hFFFF_FFFF, 4'hF, rd, er);
        reg_expect("after unmapped write", 32'h7FFF_3800);
        reg_write(32'h0000_0000);
        repeat (2) @(posedge pclk);
        reg_expect("off image", 32'h0000_0000);
        $display("test_regs done");
    endtask

    task automatic test_divide;
        logic [31:0] rd;
        logic        er;
        reg_write(32'h0002_9002);
        repeat (100) @(posedge pclk);
        check("pin enable", {31'h0, pin_oe}, 32'h1);
        check("period div 2 src 2", period, 32'd12);
        idle_mode <= 1'h1;
        apb(1'h1, 12'h000, 32'h0000_B000, 4'h2, rd, er);
        reg_write(32'h0003_B002);
        idle_mode <= 1'h0;
        repeat (100) @(posedge pclk);
        check("period held", period, 32'd12);
        apb(1'h1, 12'h000, 32'h0000_9200, 4'h2, rd, er);
        repeat (100) @(posedge pclk);
        check("period div 3", period, 32'd18);
        reg_expect("switch cleared", 32'h0003_9102);
        idle_mode <= 1'h1;
        apb(1'h1, 12'h000, 32'h0000_B000, 4'h2, rd, er);
        reg_write(32'h0003_B205);
        idle_mode <= 1'h0;
        repeat (150) @(posedge pclk);
        check("period src 5", period, 32'd36);
        $display("test_divide done");
    endtask

    task automatic test_halt;
        logic [31:0] rd;
        logic        er;
        apb(1'h1, 12'h000, 32'h0000_0000, 4'h2, rd, er);
        reg_write(32'h0002_B802);
        expect_run("running", 1'h1);
        idle_mode <= 1'h1;
        expect_run("idle stop", 1'h0);
        reg_expect("idle request", 32'h0002_B802);
        reg_write(32'h0002_9802);
        expect_run("idle run", 1'h1);
        sleep_mode <= 1'h1;
        expect_run("sleep run", 1'h1);
        apb(1'h1, 12'h000, 32'h0000_9000, 4'h2, rd, er);
        expect_run("sleep stop", 1'h0);
        reg_write(32'h0002_9A01);
        expect_run("sleep src 1", 1'h0);
        idle_mode  <= 1'h0;
        sleep_mode <= 1'h0;
        expect_run("awake src 1", 1'h1);
        apb(1'h1, 12'h000, 32'h0000_1800, 4'h2, rd, er);
        expect_run("off", 1'h0);
        reg_write(32'h0002_8001);
        repeat (4) @(posedge pclk);
        check("pin disabled", {30'h0, pin_oe, pin}, 32'h0);
        $display("test_halt done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        print_verdict;
    end

    initial
    begin
        err_count   = 0;
        n_tests     = 0;
        presetn     = 1'h0;
        pclken      = 1'h1;
        psel        = 1'h0;
        penable     = 1'h0;
        pwrite      = 1'h0;
        paddr       = 12'h000;
        pwdata      = 32'h0;
        pstrb       = 4'h0;
        idle_mode   = 1'h0;
        sleep_mode  = 1'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        test_regs;
        test_divide;
        test_halt;
        print_verdict;
    end
endmodule // testbench
